// [bench/low_speed_and_fast_timers_tb.sv]
/*
 * self-checking bench for the timer block: register reads, both timers.
 * assumes the package and the bound checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module low_speed_and_fast_timers_tb;
  // ****************************************
  // clock, reset and design
  // ****************************************
  localparam int STEP = 4; // short step keeps stepped runs brief
  localparam int CEIL = 40000; // cycle budget, well over the planned run
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  tmr_pkg::sfr_req_s sfr_req = '0;
  logic [2:0] pins = 3'h0; // internal, crystal, fast source pins
  logic [7:0] sfr_rdata;
  logic crystal_power_down;
  logic slow_irq;
  logic fast_irq;
  logic wake_request;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  wire logic [7:0] flags = {5'h00, wake_request, fast_irq, slow_irq};
  // free running 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;
  low_speed_and_fast_timers #(.STEP_CLOCKS(STEP)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .internal_slow_oscillator(pins[0]), .crystal_clock(pins[1]),
    .fast_source_clock(pins[2]), .crystal_power_down(crystal_power_down),
    .slow_irq(slow_irq), .fast_irq(fast_irq), .wake_request(wake_request));
  // ****************************************
  // tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // strobe released and one idle edge, so calls never collide in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    step(1);
    sfr_req = '0;
    step(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    step(1);
    check(sfr_rdata, exp);
    sfr_req = '0;
    step(1);
  endtask : rd_reg
  // slow toggles: 8 cycles a period leaves room for the pin synchroniser
  task automatic pulse(input int sel, input int n);
    repeat (n) begin
      pins[sel] = 1'b1;
      step(4);
      pins[sel] = 1'b0;
      step(4);
    end
  endtask : pulse
  // flag must appear on the n-th source rise exactly, then is cleared
  task automatic interval(input int sel, input int n, input logic [7:0] fl);
    pulse(sel, n - 1);
    check(flags, 8'h00);
    pulse(sel, 1);
    check(flags, fl);
    step(6);
    wr_reg(tmr_pkg::FLAG_ADDR, fl & 8'h03);
    rd_reg(tmr_pkg::FLAG_ADDR, 8'h00);
  endtask : interval
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == CEIL) begin
      miscompares++;
      $display("MISMATCH at %0t: run timed out", $time);
      finish_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin : main
    step(10);
    rst_n = 1'b1;
    rd_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h00);
    rd_reg(tmr_pkg::FAST_VALUE_HIGH_ADDR, 8'h00);
    rd_reg(tmr_pkg::FAST_VALUE_LOW_ADDR, 8'h00);
    rd_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h00);
    rd_reg(tmr_pkg::SLOW_VALUE_HIGH_ADDR, 8'h00);
    rd_reg(tmr_pkg::SLOW_VALUE_LOW_ADDR, 8'h00);
    rd_reg(tmr_pkg::FLAG_ADDR, 8'h00);
    rd_reg(tmr_pkg::ANALOG_POWER_DOWN_ADDR, 8'h71);
    rd_reg(8'h50, 8'h00); // unmapped address reads zero
    check({7'h00, crystal_power_down}, 8'h01);
    // fast single shot, /4, value 0x0100 across both bytes
    wr_reg(tmr_pkg::FAST_VALUE_HIGH_ADDR, 8'h01);
    wr_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h05);
    pulse(2, 1027);
    check(flags, 8'h00);
    pulse(2, 1);
    check(flags, 8'h06);
    pulse(2, 8);
    check(flags, 8'h06);
    rd_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h04);
    wr_reg(tmr_pkg::FLAG_ADDR, 8'h02);
    // fast auto reload, /12, value 0, restarts and a mode change midway
    wr_reg(tmr_pkg::FAST_VALUE_HIGH_ADDR, 8'h00);
    wr_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h03);
    interval(2, 12, 8'h06);
    rd_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h03);
    interval(2, 12, 8'h06);
    pulse(2, 6);
    wr_reg(tmr_pkg::FAST_VALUE_LOW_ADDR, 8'h00);
    interval(2, 12, 8'h06);
    pulse(2, 6);
    wr_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h01);
    interval(2, 12, 8'h06);
    rd_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h00);
    wr_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h03);
    pulse(2, 6);
    wr_reg(tmr_pkg::FAST_CONFIG_ADDR, 8'h02);
    pulse(2, 12);
    check(flags, 8'h00);
    // slow internal source, stepped single shot; crystal not selected
    wr_reg(tmr_pkg::SLOW_VALUE_LOW_ADDR, 8'h01);
    wr_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h09);
    pulse(1, 8);
    check(flags, 8'h00);
    interval(0, 2 * STEP, 8'h05);
    rd_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h08);
    // slow crystal source: gated while powered down, then auto reload
    wr_reg(tmr_pkg::SLOW_VALUE_LOW_ADDR, 8'h02);
    wr_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h07);
    pulse(1, 3);
    check(flags, 8'h00);
    wr_reg(tmr_pkg::ANALOG_POWER_DOWN_ADDR, 8'h61);
    check({7'h00, crystal_power_down}, 8'h00);
    rd_reg(tmr_pkg::ANALOG_POWER_DOWN_ADDR, 8'h61);
    wr_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h07);
    // crystal powered and selected: internal edges must not count
    pulse(0, 3);
    check(flags, 8'h00);
    interval(1, 3, 8'h05);
    interval(1, 3, 8'h05);
    pulse(1, 2);
    wr_reg(tmr_pkg::SLOW_VALUE_HIGH_ADDR, 8'h00);
    interval(1, 3, 8'h05);
    pulse(1, 2);
    wr_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h07);
    interval(1, 3, 8'h05);
    wr_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h06);
    pulse(1, 3);
    check(flags, 8'h00);
    rd_reg(tmr_pkg::SLOW_CONFIG_ADDR, 8'h06);
    finish_test();
  end
endmodule : low_speed_and_fast_timers_tb
`default_nettype wire

// [bench/timers_properties.sv]
/*
 * checker for the timer block: wake, power-down bit and pending flags.
 * assumes it is bound to every instance of low_speed_and_fast_timers.
 */
`timescale 1ns/1ps
`default_nettype none
module timers_properties (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire tmr_pkg::sfr_req_s sfr_req, // register access strobe
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic internal_slow_oscillator, // internal slow pin
  input wire logic crystal_clock, // crystal pin
  input wire logic fast_source_clock, // fast source pin
  input wire logic crystal_power_down, // crystal off
  input wire logic slow_irq, // slow pending flag
  input wire logic fast_irq, // fast pending flag
  input wire logic wake_request // wake from idle
);
  // ****************************************
  // helpers
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // decoded writes; a clear only counts when no source edge is in flight
  wire logic flag_wr = sfr_req.wr && (sfr_req.addr == tmr_pkg::FLAG_ADDR);
  wire logic pd_wr = sfr_req.wr && (sfr_req.addr == tmr_pkg::ANALOG_POWER_DOWN_ADDR);
  sequence s_fast_quiet;
    $stable(fast_source_clock) [*8];
  endsequence
  sequence s_slow_quiet;
    ($stable(internal_slow_oscillator) && $stable(crystal_clock)) [*8];
  endsequence
  // ****************************************
  // properties
  // ****************************************
  property p_wake;
    wake_request == (slow_irq || fast_irq);
  endproperty
  property p_pd_write;
    pd_wr |=> crystal_power_down == $past(sfr_req.wdata[tmr_pkg::CRYSTAL_PD_BIT]);
  endproperty
  property p_pd_hold;
    !pd_wr |=> $stable(crystal_power_down);
  endproperty
  property p_fast_hold;
    fast_irq && !(flag_wr && sfr_req.wdata[tmr_pkg::FAST_FLAG_BIT]) |=> fast_irq;
  endproperty
  property p_slow_hold;
    slow_irq && !(flag_wr && sfr_req.wdata[tmr_pkg::SLOW_FLAG_BIT]) |=> slow_irq;
  endproperty
  property p_fast_clear;
    s_fast_quiet ##0 (flag_wr && sfr_req.wdata[tmr_pkg::FAST_FLAG_BIT]) |=> !fast_irq;
  endproperty
  property p_slow_clear;
    s_slow_quiet ##0 (flag_wr && sfr_req.wdata[tmr_pkg::SLOW_FLAG_BIT]) |=> !slow_irq;
  endproperty
  property p_flag_read;
    sfr_req.rd && (sfr_req.addr == tmr_pkg::FLAG_ADDR)
      |=> sfr_rdata[1:0] == {$past(fast_irq), $past(slow_irq)};
  endproperty
  property p_fast_cause;
    s_fast_quiet |=> !$rose(fast_irq);
  endproperty
  property p_slow_cause;
    s_slow_quiet |=> !$rose(slow_irq);
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs from flags");
  a_pd_write: assert property (p_pd_write) else $error("power-down bit not written");
  a_pd_hold: assert property (p_pd_hold) else $error("power-down bit moved");
  a_fast_hold: assert property (p_fast_hold) else $error("fast flag dropped");
  a_slow_hold: assert property (p_slow_hold) else $error("slow flag dropped");
  a_fast_clear: assert property (p_fast_clear) else $error("fast flag not cleared");
  a_slow_clear: assert property (p_slow_clear) else $error("slow flag not cleared");
  a_flag_read: assert property (p_flag_read) else $error("flag read wrong");
  a_fast_cause: assert property (p_fast_cause) else $error("fast flag without tick");
  a_slow_cause: assert property (p_slow_cause) else $error("slow flag without tick");
endmodule : timers_properties
bind low_speed_and_fast_timers timers_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .internal_slow_oscillator(internal_slow_oscillator),
  .crystal_clock(crystal_clock), .fast_source_clock(fast_source_clock),
  .crystal_power_down(crystal_power_down), .slow_irq(slow_irq), .fast_irq(fast_irq),
  .wake_request(wake_request));
`default_nettype wire

// [rtl/interval_counter.sv]
/*
 * one interval counter: counts tick pulses up to (value + 1) and reports done.
 * assumes tick is a one-cycle pulse on clk_sys and restart clears the count.
 */
`timescale 1ns/1ps
`default_nettype none
module interval_counter #(
  parameter int WIDTH = 16 // width of the compare value
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic run, // counting allowed
  input wire logic restart, // clear count to zero
  input wire logic tick, // one count step
  input wire logic [WIDTH-1:0] limit, // compare value
  output logic done // pulse at interval end
);
  // refuse a width the compare logic cannot serve
  if (WIDTH < 1) begin : g_bad_width
    $error("interval_counter: WIDTH must be positive");
  end
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic hit;
  logic done_next;
  // last step of the interval: count already at limit
  assign hit = run && tick && !restart && (count_reg == limit);
  assign count_next = (restart || !run || hit) ? '0 :
                      (tick ? count_reg + 1'b1 : count_reg);
  assign done_next = hit;
  // state update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_reg <= '0;
      done <= 1'b0;
    end else begin
      count_reg <= count_next;
      done <= done_next;
    end
  end
endmodule : interval_counter
`default_nettype wire

// [rtl/low_speed_and_fast_timers.sv]
/*
 * slow (32 kHz) and fast (24 MHz derived) interval timers behind an 8-bit
 * special-function register port, with pending flags and wake requests.
 * assumes slow clock sources arrive as asynchronous pins and the fast
 * source clock is sampled as a pin too; processor writes are one-cycle strobes.
 */
`timescale 1ns/1ps
`default_nettype none
//Contract
// - slow reload bit: 1 auto cycle counting, 0 single shot.
// - slow enable 1 starts, 0 stops; single shot clears enable at completion.
// - writing either slow value byte while timing restarts the count.
// - rewriting an enable bit while counting restarts from zero.
// - crystal power-down bit: 1 disables, 0 enables, resets disabled.
// - fast timer uses 16-bit value from high and low bytes.
// - fast clock select: 1 divides by 4, 0 by 12; resets 0.
// - fast interval equals divided period times value plus one.
// - fast single shot clears its enable at completion.
// - fast auto reload keeps enable and restarts the next interval.
// - fast auto reload stops on enable 0; mode may change midway.
// - any fast config or value write clears the fast counter.
// - fast completion interrupt can wake the chip from idle.
// - writing a fast value byte while timing restarts the count.
// - slow source: crystal when select 1, internal oscillator when 0.
// - slow interval is period times value plus one, times 65536 when stepped.
// - slow interrupt at set value wakes idle; software clears flag.
// - any slow config or value write clears the slow counter.
module low_speed_and_fast_timers #(
  parameter int FAST_DIV_SLOW = tmr_pkg::FAST_DIV_SLOW, // /12 divider
  parameter int FAST_DIV_QUICK = tmr_pkg::FAST_DIV_QUICK, // /4 divider
  parameter int STEP_CLOCKS = tmr_pkg::STEP_CLOCKS // slow step length
) (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire tmr_pkg::sfr_req_s sfr_req, // register access strobe
  output logic [7:0] sfr_rdata, // read data, one cycle after rd
  input wire logic internal_slow_oscillator, // 32 kHz internal clock pin
  input wire logic crystal_clock, // 32768 Hz crystal clock pin
  input wire logic fast_source_clock, // 24 MHz source clock pin
  output logic crystal_power_down, // 1 keeps the crystal off
  output logic slow_irq, // slow timer pending flag
  output logic fast_irq, // fast timer pending flag
  output logic wake_request // wake from idle
);
  // refuse divider and step settings the counters cannot serve
  if (FAST_DIV_SLOW < 2 || FAST_DIV_QUICK < 2 || FAST_DIV_QUICK > FAST_DIV_SLOW) begin : g_bad_div
    $error("low_speed_and_fast_timers: bad fast dividers");
  end
  if (STEP_CLOCKS < 1) begin : g_bad_step
    $error("low_speed_and_fast_timers: bad STEP_CLOCKS");
  end
  // ****************************************
  // register file
  // ****************************************
  logic [7:0] slow_config_reg;
  logic [7:0] slow_value_high_reg;
  logic [7:0] slow_value_low_reg;
  logic [7:0] fast_config_reg;
  logic [7:0] fast_value_high_reg;
  logic [7:0] fast_value_low_reg;
  logic [7:0] analog_power_down_reg;
  logic slow_flag_reg;
  logic fast_flag_reg;
  logic [7:0] rdata_reg;
  // address decode for the write strobes; the read mux decodes with its own case
  function automatic logic hit_addr(input tmr_pkg::sfr_req_s r, input logic [7:0] a);
    hit_addr = (r.addr == a);
  endfunction : hit_addr
  wire wr_slow_cfg = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::SLOW_CONFIG_ADDR);
  wire wr_slow_hi = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::SLOW_VALUE_HIGH_ADDR);
  wire wr_slow_lo = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::SLOW_VALUE_LOW_ADDR);
  wire wr_fast_cfg = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::FAST_CONFIG_ADDR);
  wire wr_fast_hi = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::FAST_VALUE_HIGH_ADDR);
  wire wr_fast_lo = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::FAST_VALUE_LOW_ADDR);
  wire wr_analog = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::ANALOG_POWER_DOWN_ADDR);
  wire wr_flag = sfr_req.wr && hit_addr(sfr_req, tmr_pkg::FLAG_ADDR);
  // any settings write restarts that timer's count
  wire slow_restart = wr_slow_cfg || wr_slow_hi || wr_slow_lo;
  wire fast_restart = wr_fast_cfg || wr_fast_hi || wr_fast_lo;
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [2:0] pin_last_reg;
  wire [2:0] pin_raw = {fast_source_clock, crystal_clock, internal_slow_oscillator};
  wire [2:0] pin_rise = pin_sync_reg & ~pin_last_reg;
  // two flops per pin before anything looks at it; rise detect on the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_last_reg <= 3'h0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_last_reg <= pin_sync_reg;
    end
  end
  // ****************************************
  // slow timer clocking
  // ****************************************
  wire slow_step_mode = slow_config_reg[tmr_pkg::STEP_BIT];
  wire slow_clock_select = slow_config_reg[tmr_pkg::CLKSEL_BIT];
  wire slow_auto_reload = slow_config_reg[tmr_pkg::RELOAD_BIT];
  wire slow_run_enable = slow_config_reg[tmr_pkg::RUN_BIT];
  // crystal edges only count while the crystal is powered
  wire slow_src_tick = slow_clock_select ?
                       (pin_rise[1] && !analog_power_down_reg[tmr_pkg::CRYSTAL_PD_BIT]) :
                       pin_rise[0];
  localparam int STEP_W = $clog2(STEP_CLOCKS) > 0 ? $clog2(STEP_CLOCKS) : 1;
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CLOCKS - 1);
  logic [STEP_W-1:0] step_reg;
  wire step_wrap = slow_src_tick && (step_reg == STEP_LAST);
  wire slow_tick = slow_step_mode ? step_wrap : slow_src_tick;
  // prescaler for the 65536-clock step, cleared with the counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      step_reg <= '0;
    end else if (slow_restart || !slow_run_enable || !slow_step_mode || step_wrap) begin
      step_reg <= '0;
    end else if (slow_src_tick) begin
      step_reg <= step_reg + 1'b1;
    end
  end
  // ****************************************
  // fast timer clocking
  // ****************************************
  wire fast_clock_select = fast_config_reg[tmr_pkg::CLKSEL_BIT];
  wire fast_auto_reload = fast_config_reg[tmr_pkg::RELOAD_BIT];
  wire fast_run_enable = fast_config_reg[tmr_pkg::RUN_BIT];
  localparam int DIV_W = $clog2(FAST_DIV_SLOW);
  localparam logic [DIV_W-1:0] DIV_LAST_SLOW = DIV_W'(FAST_DIV_SLOW - 1);
  localparam logic [DIV_W-1:0] DIV_LAST_QUICK = DIV_W'(FAST_DIV_QUICK - 1);
  logic [DIV_W-1:0] div_reg;
  wire [DIV_W-1:0] div_last = fast_clock_select ? DIV_LAST_QUICK : DIV_LAST_SLOW;
  wire fast_tick = pin_rise[2] && (div_reg == div_last);
  // source divider; restarts with the counter so intervals are whole
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (fast_restart || !fast_run_enable || fast_tick) begin
      div_reg <= '0;
    end else if (pin_rise[2]) begin
      div_reg <= div_reg + 1'b1;
    end
  end
  // ****************************************
  // interval counters
  // ****************************************
  logic slow_done;
  logic fast_done;
  tmr_pkg::timer_cfg_s slow_cfg;
  tmr_pkg::timer_cfg_s fast_cfg;
  assign slow_cfg = '{run: slow_run_enable, auto_reload: slow_auto_reload,
                      value: {slow_value_high_reg, slow_value_low_reg}};
  assign fast_cfg = '{run: fast_run_enable, auto_reload: fast_auto_reload,
                      value: {fast_value_high_reg, fast_value_low_reg}};
  interval_counter #(.WIDTH(16)) slow_counter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(slow_cfg.run),
    .restart(slow_restart),
    .tick(slow_tick),
    .limit(slow_cfg.value),
    .done(slow_done)
  );
  interval_counter #(.WIDTH(16)) fast_counter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(fast_cfg.run),
    .restart(fast_restart),
    .tick(fast_tick),
    .limit(fast_cfg.value),
    .done(fast_done)
  );
  // ****************************************
  // register next values
  // ****************************************
  // single-shot completion drops enable; a same-cycle config write wins since it restarts
  wire slow_self_clear = slow_done && !slow_cfg.auto_reload && !wr_slow_cfg;
  wire fast_self_clear = fast_done && !fast_cfg.auto_reload && !wr_fast_cfg;
  wire [7:0] slow_config_next = wr_slow_cfg ? (sfr_req.wdata & tmr_pkg::SLOW_CFG_MASK) :
    (slow_self_clear ? (slow_config_reg & ~(8'h01 << tmr_pkg::RUN_BIT)) :
     slow_config_reg);
  wire [7:0] fast_config_next = wr_fast_cfg ? (sfr_req.wdata & tmr_pkg::FAST_CFG_MASK) :
    (fast_self_clear ? (fast_config_reg & ~(8'h01 << tmr_pkg::RUN_BIT)) :
     fast_config_reg);
  // flags: set wins over a software clear in the same cycle
  wire slow_flag_next = slow_done ||
    (slow_flag_reg && !(wr_flag && sfr_req.wdata[tmr_pkg::SLOW_FLAG_BIT]));
  wire fast_flag_next = fast_done ||
    (fast_flag_reg && !(wr_flag && sfr_req.wdata[tmr_pkg::FAST_FLAG_BIT]));
  wire [7:0] analog_next = wr_analog ? (sfr_req.wdata & tmr_pkg::ANALOG_PD_MASK) :
                           analog_power_down_reg;
  // ****************************************
  // read mux
  // ****************************************
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = 8'h00;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        tmr_pkg::SLOW_CONFIG_ADDR: rdata_next = slow_config_reg;
        tmr_pkg::SLOW_VALUE_HIGH_ADDR: rdata_next = slow_value_high_reg;
        tmr_pkg::SLOW_VALUE_LOW_ADDR: rdata_next = slow_value_low_reg;
        tmr_pkg::FAST_CONFIG_ADDR: rdata_next = fast_config_reg;
        tmr_pkg::FAST_VALUE_HIGH_ADDR: rdata_next = fast_value_high_reg;
        tmr_pkg::FAST_VALUE_LOW_ADDR: rdata_next = fast_value_low_reg;
        tmr_pkg::ANALOG_POWER_DOWN_ADDR: rdata_next = analog_power_down_reg;
        tmr_pkg::FLAG_ADDR: rdata_next = {6'h00, fast_flag_reg, slow_flag_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end
  // ****************************************
  // register and output flops
  // ****************************************
  // value bytes take writes directly; outputs all come from flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      slow_config_reg <= tmr_pkg::CONFIG_RESET;
      slow_value_high_reg <= tmr_pkg::VALUE_RESET;
      slow_value_low_reg <= tmr_pkg::VALUE_RESET;
      fast_config_reg <= tmr_pkg::CONFIG_RESET;
      fast_value_high_reg <= tmr_pkg::VALUE_RESET;
      fast_value_low_reg <= tmr_pkg::VALUE_RESET;
      analog_power_down_reg <= tmr_pkg::ANALOG_PD_RESET & tmr_pkg::ANALOG_PD_MASK;
      slow_flag_reg <= 1'b0;
      fast_flag_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      slow_config_reg <= slow_config_next;
      if (wr_slow_hi) slow_value_high_reg <= sfr_req.wdata;
      if (wr_slow_lo) slow_value_low_reg <= sfr_req.wdata;
      fast_config_reg <= fast_config_next;
      if (wr_fast_hi) fast_value_high_reg <= sfr_req.wdata;
      if (wr_fast_lo) fast_value_low_reg <= sfr_req.wdata;
      analog_power_down_reg <= analog_next;
      slow_flag_reg <= slow_flag_next;
      fast_flag_reg <= fast_flag_next;
      rdata_reg <= rdata_next;
    end
  end
  // pending flags double as wake requests from either idle mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crystal_power_down <= 1'b1;
      slow_irq <= 1'b0;
      fast_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      crystal_power_down <= analog_next[tmr_pkg::CRYSTAL_PD_BIT];
      slow_irq <= slow_flag_next;
      fast_irq <= fast_flag_next;
      wake_request <= slow_flag_next || fast_flag_next;
    end
  end
  assign sfr_rdata = rdata_reg;
endmodule : low_speed_and_fast_timers
`default_nettype wire

// [rtl/tmr_pkg.sv]
/*
 * constants, register map and carrier types shared by the timer block.
 * assumes an 8-bit special-function register port on the clk_sys domain.
 */
`default_nettype none
package tmr_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ANALOG_POWER_DOWN_ADDR = 8'h2D;
  localparam logic [7:0] FAST_CONFIG_ADDR = 8'h84;
  localparam logic [7:0] FAST_VALUE_HIGH_ADDR = 8'h85;
  localparam logic [7:0] FAST_VALUE_LOW_ADDR = 8'h86;
  localparam logic [7:0] SLOW_CONFIG_ADDR = 8'h93;
  localparam logic [7:0] SLOW_VALUE_HIGH_ADDR = 8'h94;
  localparam logic [7:0] SLOW_VALUE_LOW_ADDR = 8'h95;
  localparam logic [7:0] FLAG_ADDR = 8'h96;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int RUN_BIT = 0;
  localparam int RELOAD_BIT = 1;
  localparam int CLKSEL_BIT = 2;
  localparam int STEP_BIT = 3;
  localparam int CRYSTAL_PD_BIT = 4;
  localparam int SLOW_FLAG_BIT = 0;
  localparam int FAST_FLAG_BIT = 1;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] ANALOG_PD_RESET = 8'hFF;
  localparam logic [7:0] SLOW_CFG_MASK = 8'h0F;
  localparam logic [7:0] FAST_CFG_MASK = 8'h07;
  localparam logic [7:0] ANALOG_PD_MASK = 8'h71;
  // ****************************************
  // timing
  // ****************************************
  localparam int FAST_DIV_SLOW = 12;
  localparam int FAST_DIV_QUICK = 4;
  localparam int STEP_CLOCKS = 65536;
  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;
  typedef struct packed {
    logic run;
    logic auto_reload;
    logic [15:0] value;
  } timer_cfg_s;
endpackage : tmr_pkg
`default_nettype wire
